// file: hdl/ccc_calendar_ctrl.sv
// Calendar counter control: Wishbone registers, flags, interrupt and clock outputs.
// Assumes alarm_match is a one-cycle pulse on clk_sys and the sub clock is a pin.
// Notes on behaviour
// - Enable off: control writes ignored, reads default
// - Output enables changed while running may glitch
// - Read-modify-write of flag register may clear flags
// - Writing one to a flag keeps it
// - Stopped divided pin goes low within two
// - Stopped 512 Hz pin may pulse one period
// - First divided interval after start may be short
module ccc_calendar_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic crystal_sub_clock,
  input wire logic alarm_match,
  output logic irq,
  output logic fast_clk_out,
  output logic slow_clk_out,
  output logic divided_clock_pin,
  output logic access_wait_request
);
  // Timebase drives tick, level and count back over the carrier
  ccc_tbase_if #(.W(ccc_pkg::PRESCALE_W)) tb ();

  ccc_timebase #(.W(ccc_pkg::PRESCALE_W)) u_timebase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .crystal_sub_clock(crystal_sub_clock),
    .tb(tb.src)
  );

  // ==========================================================
  // Control state
  logic cal_periph_enable;
  logic counter_run;
  logic fast_clk_out_enable;
  logic slow_clk_out_enable;
  logic fixed_cycle_flag;
  logic alarm_detect_flag;
  logic [2:0] interval_sel;
  logic fixed_cycle_irq_enable;
  logic div_out_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic next_cal_periph_enable;
  logic next_counter_run;
  logic next_fast_clk_out_enable;
  logic next_slow_clk_out_enable;
  logic next_access_wait_request;
  logic next_fixed_cycle_flag;
  logic next_alarm_detect_flag;
  logic [2:0] next_interval_sel;
  logic next_fixed_cycle_irq_enable;
  logic next_div_out_enable;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic next_irq;
  logic next_fast_clk_out;
  logic next_slow_clk_out;
  logic next_divided_clock_pin;
  logic next_wb_ack;
  logic [31:0] next_wb_dat_r;

  // Bus decode
  logic req;
  logic wr;
  logic ctl_sel;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic fix_evt;
  logic [3:0] shamt;
  logic [14:0] fix_mask;

  // Request is live until the answer goes out; only the low byte lane is stored
  assign req = wb_cyc & wb_stb & ~wb_ack;
  assign wr = req & wb_we & wb_sel[0];
  assign wbyte = wb_dat_w[7:0];
  assign ctl_sel = (wb_adr == ccc_pkg::OFS_CTLA) | (wb_adr == ccc_pkg::OFS_CTLB) | (wb_adr == ccc_pkg::OFS_CTLC);
  assign tb.run = counter_run;

  // ==========================================================
  // Fixed-cycle event: prescaler wraps at the selected width
  always_comb begin
    shamt = {1'b0, interval_sel} + ccc_pkg::ICT_BASE_W;
    fix_mask = 15'((17'h1 << shamt) - 17'h1);
    // Interval zero keeps the fixed-cycle event off entirely
    fix_evt = tb.tick & counter_run & (interval_sel != 3'h0) & ((tb.count & fix_mask) == fix_mask);
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr)
      ccc_pkg::OFS_PER: begin
        rd_byte[ccc_pkg::PER_EN_BIT] = cal_periph_enable;
      end
      ccc_pkg::OFS_CTLA: begin
        rd_byte[ccc_pkg::CTLA_RUN_BIT] = counter_run;
        rd_byte[ccc_pkg::CTLA_FAST_BIT] = fast_clk_out_enable;
        rd_byte[ccc_pkg::CTLA_SLOW_BIT] = slow_clk_out_enable;
      end
      ccc_pkg::OFS_CTLB: begin
        rd_byte[ccc_pkg::CTLB_WAIT_BIT] = access_wait_request;
        rd_byte[ccc_pkg::CTLB_FIX_BIT] = fixed_cycle_flag;
        rd_byte[ccc_pkg::CTLB_ALM_BIT] = alarm_detect_flag;
      end
      ccc_pkg::OFS_CTLC: begin
        rd_byte[ccc_pkg::CTLC_ICT_LSB +: 3] = interval_sel;
        rd_byte[ccc_pkg::CTLC_DIVEN_BIT] = div_out_enable;
        rd_byte[ccc_pkg::CTLC_IRQEN_BIT] = fixed_cycle_irq_enable;
      end
      ccc_pkg::OFS_IST: begin
        rd_byte[1:0] = irq_status;
      end
      ccc_pkg::OFS_IMSK: begin
        rd_byte[1:0] = irq_mask;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    if (ctl_sel && !cal_periph_enable) begin
      rd_byte = ccc_pkg::RST_REG; // Disabled block shows defaults
    end
  end

  // ==========================================================
  // Next values of registers, flags and outputs
  always_comb begin
    next_cal_periph_enable = cal_periph_enable;
    next_counter_run = counter_run;
    next_fast_clk_out_enable = fast_clk_out_enable;
    next_slow_clk_out_enable = slow_clk_out_enable;
    next_access_wait_request = access_wait_request;
    next_interval_sel = interval_sel;
    next_fixed_cycle_irq_enable = fixed_cycle_irq_enable;
    next_div_out_enable = div_out_enable;
    next_irq_mask = irq_mask;
    next_fixed_cycle_flag = fixed_cycle_flag;
    next_alarm_detect_flag = alarm_detect_flag;
    next_irq_status = irq_status;
    if (wr && wb_adr == ccc_pkg::OFS_PER) begin
      next_cal_periph_enable = wbyte[ccc_pkg::PER_EN_BIT];
    end
    // Control writes only land while the block is enabled
    if (wr && cal_periph_enable) begin
      if (wb_adr == ccc_pkg::OFS_CTLA) begin
        next_counter_run = wbyte[ccc_pkg::CTLA_RUN_BIT];
        next_fast_clk_out_enable = wbyte[ccc_pkg::CTLA_FAST_BIT];
        next_slow_clk_out_enable = wbyte[ccc_pkg::CTLA_SLOW_BIT];
      end
      if (wb_adr == ccc_pkg::OFS_CTLB) begin
        next_access_wait_request = wbyte[ccc_pkg::CTLB_WAIT_BIT];
        // Zero clears, one keeps; a stale read-back zero clears too
        if (!wbyte[ccc_pkg::CTLB_FIX_BIT]) begin
          next_fixed_cycle_flag = 1'b0;
        end
        if (!wbyte[ccc_pkg::CTLB_ALM_BIT]) begin
          next_alarm_detect_flag = 1'b0;
        end
      end
      if (wb_adr == ccc_pkg::OFS_CTLC) begin
        next_interval_sel = wbyte[ccc_pkg::CTLC_ICT_LSB +: 3];
        next_div_out_enable = wbyte[ccc_pkg::CTLC_DIVEN_BIT];
        next_fixed_cycle_irq_enable = wbyte[ccc_pkg::CTLC_IRQEN_BIT];
      end
    end
    if (wr && wb_adr == ccc_pkg::OFS_IST) begin
      next_irq_status = irq_status & ~wbyte[1:0]; // Write one to clear
    end
    if (wr && wb_adr == ccc_pkg::OFS_IMSK) begin
      next_irq_mask = wbyte[1:0];
    end
    // Events win over a clear in the same cycle
    if (fix_evt) begin
      next_fixed_cycle_flag = 1'b1;
    end
    if (alarm_match) begin
      next_alarm_detect_flag = 1'b1;
      next_irq_status[ccc_pkg::IRQ_ALM_BIT] = 1'b1;
    end
    if (fix_evt && fixed_cycle_irq_enable) begin
      next_irq_status[ccc_pkg::IRQ_FIX_BIT] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
    // Enables gate the outputs directly, so a change while running may glitch
    next_fast_clk_out = fast_clk_out_enable & tb.sub_level;
    next_slow_clk_out = slow_clk_out_enable & counter_run & tb.count[ccc_pkg::HZ1_BIT];
    // Pin moves only on sub-clock ticks: stop lands within two
    next_divided_clock_pin = divided_clock_pin;
    if (tb.tick) begin
      next_divided_clock_pin = div_out_enable & counter_run & tb.count[ccc_pkg::DIV512_BIT];
    end
    // Prescaler phase is not aligned to the enable
    next_wb_ack = req;
    next_wb_dat_r = (req && !wb_we) ? {24'h000000, rd_byte} : 32'h00000000;
  end

  // Register stage; reset puts every bit at its default
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cal_periph_enable <= 1'b0;
      counter_run <= 1'b0;
      fast_clk_out_enable <= 1'b0;
      slow_clk_out_enable <= 1'b0;
      access_wait_request <= 1'b0;
      fixed_cycle_flag <= 1'b0;
      alarm_detect_flag <= 1'b0;
      interval_sel <= 3'h0;
      fixed_cycle_irq_enable <= 1'b0;
      div_out_enable <= 1'b0;
      irq_status <= ccc_pkg::RST_IRQ;
      irq_mask <= ccc_pkg::RST_IRQ;
      irq <= 1'b0;
      fast_clk_out <= 1'b0;
      slow_clk_out <= 1'b0;
      divided_clock_pin <= 1'b0;
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      cal_periph_enable <= next_cal_periph_enable;
      counter_run <= next_counter_run;
      fast_clk_out_enable <= next_fast_clk_out_enable;
      slow_clk_out_enable <= next_slow_clk_out_enable;
      access_wait_request <= next_access_wait_request;
      fixed_cycle_flag <= next_fixed_cycle_flag;
      alarm_detect_flag <= next_alarm_detect_flag;
      interval_sel <= next_interval_sel;
      fixed_cycle_irq_enable <= next_fixed_cycle_irq_enable;
      div_out_enable <= next_div_out_enable;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      fast_clk_out <= next_fast_clk_out;
      slow_clk_out <= next_slow_clk_out;
      divided_clock_pin <= next_divided_clock_pin;
      wb_ack <= next_wb_ack;
      wb_dat_r <= next_wb_dat_r;
    end
  end

  // ==========================================================
  // Assertion helpers: sub-clock ticks since the divided output was stopped
  logic [1:0] stop_ticks;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (div_out_enable && counter_run)) begin
      stop_ticks <= 2'h0;
    end else if (tb.tick && stop_ticks != 2'h3) begin
      stop_ticks <= 2'(stop_ticks + 2'h1);
    end
  end

  // Every check below runs on clk_sys; all but a_reset_default sleep while reset is low
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Bus access and fixed-cycle interrupt steps
  sequence s_ctl_write_off;
    wr && ctl_sel && !cal_periph_enable;
  endsequence
  sequence s_ctl_read_off;
    req && !wb_we && ctl_sel && !cal_periph_enable;
  endsequence
  sequence s_keep_write;
    wr && cal_periph_enable && wb_adr == ccc_pkg::OFS_CTLB && wbyte[ccc_pkg::CTLB_FIX_BIT] && fixed_cycle_flag;
  endsequence
  sequence s_fix_irq;
    fix_evt && fixed_cycle_irq_enable && irq_mask[ccc_pkg::IRQ_FIX_BIT];
  endsequence
  // Flag and register write steps
  sequence s_keep_alarm;
    wr && cal_periph_enable && wb_adr == ccc_pkg::OFS_CTLB && wbyte[ccc_pkg::CTLB_ALM_BIT] && alarm_detect_flag;
  endsequence
  sequence s_ctlb_write;
    wr && cal_periph_enable && wb_adr == ccc_pkg::OFS_CTLB;
  endsequence
  sequence s_ctla_write;
    wr && cal_periph_enable && wb_adr == ccc_pkg::OFS_CTLA;
  endsequence
  sequence s_status_clear;
    wr && wb_adr == ccc_pkg::OFS_IST && wbyte[ccc_pkg::IRQ_ALM_BIT] && !alarm_match;
  endsequence

  a_ack_after_req: assert property (req |=> wb_ack ##1 !wb_ack)
    else $error("Bus ack not a single pulse after request");
  a_gate_write_off: assert property (s_ctl_write_off |=> $stable({counter_run, interval_sel, div_out_enable}))
    else $error("Control write landed while disabled");
  a_gate_read_off: assert property (s_ctl_read_off |=> wb_ack && wb_dat_r == 32'h00000000)
    else $error("Disabled control read not default");
  a_flag_one_keeps: assert property (s_keep_write |=> fixed_cycle_flag)
    else $error("Writing one cleared a flag");
  a_flag_set_wins: assert property (fix_evt |=> fixed_cycle_flag)
    else $error("Event lost against clear");
  a_fix_irq_path: assert property (s_fix_irq |=> irq)
    else $error("Fixed-cycle event did not raise irq");
  a_div_stop_low: assert property (stop_ticks >= 2'h2 |-> !divided_clock_pin)
    else $error("Divided pin still high after two sub clocks");
  a_div_edge_tick: assert property ($changed(divided_clock_pin) |-> $past(tb.tick))
    else $error("Divided pin moved off a sub-clock tick");
  a_fast_gate_off: assert property (!fast_clk_out_enable |=> !fast_clk_out)
    else $error("Fast clock out while disabled");
  a_reset_default: assert property (disable iff (1'b0) !rst_n |=> !counter_run && !irq && !fixed_cycle_flag)
    else $error("Control bits not default after reset");

  // ==========================================================
  // Register writes and read data
  a_wait_store: assert property (s_ctlb_write |=> access_wait_request == $past(wbyte[ccc_pkg::CTLB_WAIT_BIT]))
    else $error("Wait bit not stored from enabled write");
  a_run_store: assert property (s_ctla_write |=> counter_run == $past(wbyte[ccc_pkg::CTLA_RUN_BIT]))
    else $error("Run bit not stored from enabled write");
  a_dat_zero_idle: assert property (!wb_ack |-> wb_dat_r == 32'h00000000)
    else $error("Read data not zero outside ack");

  // ==========================================================
  // Flags, interrupt, clock outputs and prescaler hold
  a_alarm_one_keeps: assert property (s_keep_alarm |=> alarm_detect_flag)
    else $error("Writing one cleared the alarm flag");
  a_alarm_set_wins: assert property (alarm_match |=> alarm_detect_flag && irq_status[ccc_pkg::IRQ_ALM_BIT])
    else $error("Alarm event lost against clear");
  a_status_w1c: assert property (s_status_clear |=> !irq_status[ccc_pkg::IRQ_ALM_BIT])
    else $error("Status bit not cleared by writing one");
  a_alarm_irq_path: assert property (alarm_match && irq_mask[ccc_pkg::IRQ_ALM_BIT] && !wr |=> irq)
    else $error("Alarm event did not raise irq");
  a_slow_gate_off: assert property (!slow_clk_out_enable || !counter_run |=> !slow_clk_out)
    else $error("Slow clock out while disabled or stopped");
  a_div_off_tick: assert property (!div_out_enable && tb.tick |=> !divided_clock_pin)
    else $error("Divided pin high after a tick while disabled");
  a_prescale_held: assert property (!counter_run |=> tb.count == '0)
    else $error("Prescaler not held at zero while stopped");
endmodule

// file: hdl/ccc_pkg.sv
// Constants shared by the calendar counter control block and its timebase.
// Assumes a 32-bit classic Wishbone bus with byte addresses and 8-bit registers.
package ccc_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PER = 8'h00;
  localparam logic [7:0] OFS_CTLA = 8'h04;
  localparam logic [7:0] OFS_CTLB = 8'h08;
  localparam logic [7:0] OFS_CTLC = 8'h0c;
  localparam logic [7:0] OFS_IST = 8'h10;
  localparam logic [7:0] OFS_IMSK = 8'h14;
  // ==========================================================
  // Field positions
  localparam int PER_EN_BIT = 0;
  localparam int CTLA_SLOW_BIT = 4;
  localparam int CTLA_FAST_BIT = 5;
  localparam int CTLA_RUN_BIT = 7;
  localparam int CTLB_WAIT_BIT = 0;
  localparam int CTLB_FIX_BIT = 3;
  localparam int CTLB_ALM_BIT = 4;
  localparam int CTLC_ICT_LSB = 0;
  localparam int CTLC_DIVEN_BIT = 6;
  localparam int CTLC_IRQEN_BIT = 7;
  localparam int IRQ_FIX_BIT = 0;
  localparam int IRQ_ALM_BIT = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // ==========================================================
  // Timebase figures
  localparam int SUB_CLK_HZ = 32768;
  localparam int PRESCALE_W = 15;
  localparam int DIV512_BIT = 5;
  localparam int HZ1_BIT = 14;
  localparam logic [3:0] ICT_BASE_W = 4'h7;
  localparam int DIV_STOP_MAX_SUB = 2;
endpackage

// file: hdl/ccc_tbase_if.sv
// Carrier between the control block and its sub-clock timebase.
// Assumes both ends run on clk_sys.
interface ccc_tbase_if #(parameter int W = 15);
  logic run;
  logic tick;
  logic sub_level;
  logic [W-1:0] count;
  modport src (input run, output tick, output sub_level, output count);
  modport snk (output run, input tick, input sub_level, input count);
endinterface

// file: hdl/ccc_timebase.sv
// Sub-clock timebase: synchronises the crystal sub clock and runs a prescaler.
// Assumes the crystal sub clock is far slower than clk_sys.
module ccc_timebase #(
  parameter int W = ccc_pkg::PRESCALE_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic crystal_sub_clock,
  ccc_tbase_if.src tb
);
  logic [2:0] sync;
  logic lvl;
  logic tick;
  logic [W-1:0] count;
  logic [2:0] next_sync;
  logic next_lvl;
  logic next_tick;
  logic [W-1:0] next_count;

  // ==========================================================
  // Synchroniser, level filter and prescaler
  always_comb begin
    next_sync = {sync[1:0], crystal_sub_clock};
    next_lvl = (sync[1] == sync[2]) ? sync[2] : lvl; // Stages two and three agree
    next_tick = next_lvl & ~lvl;
    if (!tb.run) begin
      next_count = '0; // Stopped prescaler restarts from zero
    end else if (tick) begin
      next_count = W'(count + 1'b1);
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync <= 3'h0;
      lvl <= 1'b0;
      tick <= 1'b0;
      count <= '0;
    end else begin
      sync <= next_sync;
      lvl <= next_lvl;
      tick <= next_tick;
      count <= next_count;
    end
  end

  assign tb.tick = tick;
  assign tb.sub_level = lvl;
  assign tb.count = count;
endmodule

// file: tb/ccc_calendar_ctrl_tb.sv
// Self-checking bench for the calendar counter control block.
// Assumes the block answers each Wishbone request with a one-cycle ack and runs on clk_sys alone.
module ccc_calendar_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and bookkeeping
  logic clk_sys, rst_n, wb_cyc, wb_stb, wb_we, crystal_sub_clock, alarm_match;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic wb_ack, irq, fast_clk_out, slow_clk_out, divided_clock_pin, access_wait_request;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 30;
  int sub_cnt = 0;
  int n;
  logic [7:0] v;
  logic [31:0] exp_q[$];
  string nm[5] = '{"divided pin", "irq", "fast out", "wait out", "slow out"};
  localparam int SUB_PER = 4;
  localparam logic [7:0] RUNAB = 8'hb0;
  localparam logic [7:0] WAITB = 8'h01 << ccc_pkg::CTLB_WAIT_BIT;
  localparam logic [7:0] FIX = 8'h01 << ccc_pkg::CTLB_FIX_BIT;
  localparam logic [7:0] ALM = 8'h01 << ccc_pkg::CTLB_ALM_BIT;
  localparam logic [7:0] DIVB = 8'h01 << ccc_pkg::CTLC_DIVEN_BIT;
  localparam logic [7:0] CTLC_ON = 8'h81 | DIVB;
  logic [7:0] offs[6] = '{ccc_pkg::OFS_PER, ccc_pkg::OFS_CTLA, ccc_pkg::OFS_CTLB, ccc_pkg::OFS_CTLC,
    ccc_pkg::OFS_IST, ccc_pkg::OFS_IMSK};

  // ==========================================================
  // Device under test
  ccc_calendar_ctrl i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .crystal_sub_clock(crystal_sub_clock), .alarm_match(alarm_match), .irq(irq),
    .fast_clk_out(fast_clk_out), .slow_clk_out(slow_clk_out), .divided_clock_pin(divided_clock_pin),
    .access_wait_request(access_wait_request)
  );

  // ==========================================================
  // Clocks
  // System clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Sub clock sped up to one period per SUB_PER system cycles
  always @(posedge clk_sys) begin
    sub_cnt <= (sub_cnt == SUB_PER / 2 - 1) ? 0 : sub_cnt + 1;
    if (sub_cnt == SUB_PER / 2 - 1) crystal_sub_clock <= ~crystal_sub_clock;
  end

  // ==========================================================
  // Compare tasks and closing report
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error read data expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_pin(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Read data monitor: oldest note against each read ack
  always @(posedge clk_sys) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) cmp_rd(exp_q.pop_front(), wb_dat_r);
  end

  // ==========================================================
  // Bus and pin helpers
  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
    int i;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat_w <= {24'h000000, dat};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (wb_ack === 1'b1) break;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      $display("Error bus ack timeout");
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    xfer(1'b1, adr, dat, 4'hf);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    xfer(1'b0, adr, 8'h00, 4'hf);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return divided_clock_pin;
      1: return irq;
      2: return fast_clk_out;
      3: return access_wait_request;
      default: return slow_clk_out;
    endcase
  endfunction

  // Output level one and a half cycles after the last bus edge
  task automatic chk(input int w, input logic e);
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmp_pin(nm[w], e, pick(w));
  endtask

  // Bounded wait for an output level; n holds the cycles spent
  task automatic wait_sig(input int w, input logic e, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge clk_sys);
      if (pick(w) === e) break;
    end
    if (n == lim) begin
      n_mismatch++;
      $display("Error %s wait timeout", nm[w]);
      conclude();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h00000000;
    crystal_sub_clock = 1'b0;
    alarm_match = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    // Control writes while the peripheral is disabled
    wr(ccc_pkg::OFS_CTLA, RUNAB);
    wr(ccc_pkg::OFS_CTLB, WAITB);
    wr(ccc_pkg::OFS_CTLC, CTLC_ON);
    rd(ccc_pkg::OFS_CTLA, 8'h00);
    rd(ccc_pkg::OFS_CTLC, 8'h00);
    chk(3, 1'b0);
    // Enable first, bit 1 kept clear
    wr(ccc_pkg::OFS_PER, 8'h01);
    rd(ccc_pkg::OFS_PER, 8'h01);
    v = 8'($random(seed));
    wr(8'h20, v);
    rd(8'h20, 8'h00);
    xfer(1'b1, ccc_pkg::OFS_CTLA, RUNAB, 4'he);
    rd(ccc_pkg::OFS_CTLA, 8'h00);
    // Random wait bit, with random bits at the clear flag positions
    repeat (4) begin
      v = 8'($random(seed));
      wr(ccc_pkg::OFS_CTLB, v & (WAITB | FIX | ALM));
      chk(3, v[0]);
      rd(ccc_pkg::OFS_CTLB, v & WAITB);
    end
    wr(ccc_pkg::OFS_CTLB, 8'h00);
    // Alarm event: flag, status, mask and clearing
    wr(ccc_pkg::OFS_IMSK, 8'h02);
    @(posedge clk_sys);
    alarm_match <= 1'b1;
    @(posedge clk_sys);
    alarm_match <= 1'b0;
    chk(1, 1'b1);
    rd(ccc_pkg::OFS_CTLB, ALM);
    wr(ccc_pkg::OFS_CTLB, ALM);
    rd(ccc_pkg::OFS_CTLB, ALM);
    wr(ccc_pkg::OFS_CTLB, 8'h00);
    rd(ccc_pkg::OFS_CTLB, 8'h00);
    rd(ccc_pkg::OFS_IST, 8'h02);
    wr(ccc_pkg::OFS_IMSK, 8'h00);
    chk(1, 1'b0);
    wr(ccc_pkg::OFS_IMSK, 8'h02);
    chk(1, 1'b1);
    wr(ccc_pkg::OFS_IST, 8'h02);
    rd(ccc_pkg::OFS_IST, 8'h00);
    chk(1, 1'b0);
    // Run with outputs and the shortest fixed-cycle interval
    wr(ccc_pkg::OFS_IMSK, 8'h01);
    wr(ccc_pkg::OFS_CTLC, CTLC_ON & ~8'h80);
    wr(ccc_pkg::OFS_CTLC, CTLC_ON);
    wr(ccc_pkg::OFS_CTLA, RUNAB);
    wait_sig(2, 1'b1, 4 * SUB_PER);
    wait_sig(2, 1'b0, 4 * SUB_PER);
    wait_sig(0, 1'b1, 2000);
    wait_sig(1, 1'b1, 4000);
    rd(ccc_pkg::OFS_IST, 8'h01);
    rd(ccc_pkg::OFS_CTLB, FIX);
    wr(ccc_pkg::OFS_CTLB, FIX);
    rd(ccc_pkg::OFS_CTLB, FIX);
    // Stop the divided pin right after it rises
    wait_sig(0, 1'b0, 2000);
    wait_sig(0, 1'b1, 2000);
    wr(ccc_pkg::OFS_CTLC, CTLC_ON & ~DIVB);
    wait_sig(0, 1'b0, 2 * SUB_PER + 8);
    repeat (400) @(negedge clk_sys);
    chk(0, 1'b0);
    // Slow output rises once the prescaler top bit sets
    wait_sig(4, 1'b1, 70000);
    wr(ccc_pkg::OFS_CTLA, 8'h00);
    chk(2, 1'b0);
    chk(4, 1'b0);
    // Disable again: reads fall back to defaults
    wr(ccc_pkg::OFS_PER, 8'h00);
    rd(ccc_pkg::OFS_CTLB, 8'h00);
    rd(ccc_pkg::OFS_CTLC, 8'h00);
    @(negedge clk_sys);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("Error read count expected 0 seen %0d", exp_q.size());
    end
    conclude();
  end
endmodule
